// ---- irs_defs.vh ----
// Purpose: Constants for the two-wire register access slave
// Assumes: Included by irs_i2c_slave.v only
// Notes:   Functional notes list follows
//
// Functional notes
// R1: Start is SDA fall while SCL high
// R2: Stop is SDA rise while SCL high
// R3: SDA changes only while SCL low
// R4: Bus busy from start until stop
// R5: Every byte is followed by acknowledge bit
// R6: Transmitter releases after 8th, receiver after 9th
// R7: No general call, start byte, high-speed
// R8: Answer only own 7-bit address, default zero
// R9: Address is factory option up to 1111110
// R10: Master sends address, then 5-bit pointer byte
// R11: Acknowledge address, pointer and data bytes
// R12: Third write byte stored at pointer
// R13: Further bytes go to next addresses
// R14: Pointer wraps after last register
// R15: Master ends write with stop or restart
// R16: Master restarts and resends address for read
// R17: Read sends pointed register MSB first
// R18: Master NACK ends read, device releases SDA
// R19: Master ACK makes device send next register
// R20: Master ends incrementing read with NACK
// R21: Watchdog config writable only when key 0x5A
// R22: Interface active only while select pin high
// R23: Address mismatch ignored until next start
`ifndef IRS_DEFS_VH
`define IRS_DEFS_VH

`define IRS_SLAVE_ADDR   7'h00
`define IRS_ADDR_RSVD0   5'h00
`define IRS_ADDR_RSVD1   5'h01
`define IRS_ADDR_KEY     5'h02
`define IRS_ADDR_WDCFG   5'h03
`define IRS_KEY_UNLOCK   8'h5A
`define IRS_KEY_RST      8'h00
`define IRS_WDCFG_RST    8'h09
`define IRS_GEN_RST      8'h00
`define IRS_PTR_W        5

`endif

// ---- irs_i2c_slave.v ----
// Purpose: Two-wire slave giving byte access to a 32-entry register space
// Assumes: SCL and SDA are oversampled by core_clk_i, well above bus rate
// Notes:   Open-drain SDA: sda_o is always low, sda_oe_o pulls the wire
`timescale 1ns/100ps
`default_nettype none
`include "irs_defs.vh"

module irs_i2c_slave
#(
	parameter [6:0] SLAVE_ADDR = `IRS_SLAVE_ADDR // see R9
)
(
	input  wire       core_clk_i,
	input  wire       reset_n_i,
	input  wire       i2c_sel_i,
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output reg        sda_oe_o,
	output reg        busy_o,
	output reg  [7:0] wd_unlock_key_o,
	output reg  [7:0] wd_config_o,
	output reg        wd_unlocked_o
);

// ----------------------------------------------------------------
// State codes
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_RX   = 3'h2;
localparam [2:0] ST_ACK  = 3'h3;
localparam [2:0] ST_TX   = 3'h4;
localparam [2:0] ST_MACK = 3'h5;
localparam [2:0] ST_IGN  = 3'h6;

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg        scl_m_reg;
reg        scl_s_reg;
reg        scl_d_reg;
reg        sda_m_reg;
reg        sda_s_reg;
reg        sda_d_reg;
reg        sel_m_reg;
reg        sel_s_reg;
reg  [2:0] state_reg;
reg  [2:0] cnt_reg;
reg        full_reg;
reg  [7:0] shift_reg;
reg        rw_reg;
reg        ptr_phase_reg;
reg        mack_reg;
reg  [`IRS_PTR_W-1:0] ptr_reg;
reg  [7:0] mem [`IRS_ADDR_WDCFG+1:31];
reg  [7:0] rd_data;
wire       scl_rise;
wire       scl_fall;
wire       start_ev;
wire       stop_ev;
wire [`IRS_PTR_W-1:0] ptr_inc;
integer    i;

// Pin is open drain, only ever pulled low
assign sda_o = 1'b0;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Two flops per pin, a third stage on SCL and SDA for edge detection
always @(posedge core_clk_i)
begin
	if (!reset_n_i)
	begin
		scl_m_reg <= 1'b1;
		scl_s_reg <= 1'b1;
		scl_d_reg <= 1'b1;
		sda_m_reg <= 1'b1;
		sda_s_reg <= 1'b1;
		sda_d_reg <= 1'b1;
		sel_m_reg <= 1'b0;
		sel_s_reg <= 1'b0;
	end
	else
	begin
		scl_m_reg <= scl_i;
		scl_s_reg <= scl_m_reg;
		scl_d_reg <= scl_s_reg;
		sda_m_reg <= sda_i;
		sda_s_reg <= sda_m_reg;
		sda_d_reg <= sda_s_reg;
		sel_m_reg <= i2c_sel_i;
		sel_s_reg <= sel_m_reg;
	end
end

// Bus events seen from synchronised levels
assign scl_rise = scl_s_reg & ~scl_d_reg;
assign scl_fall = ~scl_s_reg & scl_d_reg;
assign start_ev = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg; // see R1
assign stop_ev  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg; // see R2
assign ptr_inc  = ptr_reg + 1'b1; // see R14

// ----------------------------------------------------------------
// Register read mux
// ----------------------------------------------------------------
// Reserved locations read as zero
always @*
begin
	rd_data = 8'h00;
	case (ptr_reg)
		`IRS_ADDR_RSVD0: rd_data = 8'h00;
		`IRS_ADDR_RSVD1: rd_data = 8'h00;
		`IRS_ADDR_KEY:   rd_data = wd_unlock_key_o;
		`IRS_ADDR_WDCFG: rd_data = wd_config_o;
		default:         rd_data = mem[ptr_reg];
	endcase
end

// ----------------------------------------------------------------
// Protocol engine and register file
// ----------------------------------------------------------------
// Samples SDA on SCL rise, changes SDA only on SCL fall
always @(posedge core_clk_i)
begin
	if (!reset_n_i)
	begin
		state_reg       <= ST_IDLE;
		cnt_reg         <= 3'h0;
		full_reg        <= 1'b0;
		shift_reg       <= 8'h00;
		rw_reg          <= 1'b0;
		ptr_phase_reg   <= 1'b0;
		mack_reg        <= 1'b0;
		ptr_reg         <= {`IRS_PTR_W{1'b0}};
		sda_oe_o        <= 1'b0;
		busy_o          <= 1'b0;
		wd_unlock_key_o <= `IRS_KEY_RST;
		wd_config_o     <= `IRS_WDCFG_RST;
		wd_unlocked_o   <= 1'b0;
		for (i = `IRS_ADDR_WDCFG + 1; i < 32; i = i + 1)
			mem[i] <= `IRS_GEN_RST;
	end
	else
	begin
		wd_unlocked_o <= (wd_unlock_key_o == `IRS_KEY_UNLOCK);
		if (!sel_s_reg)
		begin
			// Four-wire mode selected: stay off the bus
			state_reg <= ST_IDLE; // see R22
			sda_oe_o  <= 1'b0;
			busy_o    <= 1'b0;
			full_reg  <= 1'b0;
		end
		else if (start_ev)
		begin
			// Start or repeated start opens a new transfer
			state_reg     <= ST_ADDR; // see R1
			busy_o        <= 1'b1; // see R4
			sda_oe_o      <= 1'b0;
			cnt_reg       <= 3'h0;
			full_reg      <= 1'b0;
			ptr_phase_reg <= 1'b1;
		end
		else if (stop_ev)
		begin
			// Stop ends the transfer and frees the bus
			state_reg <= ST_IDLE; // see R2
			busy_o    <= 1'b0; // see R4
			sda_oe_o  <= 1'b0;
			full_reg  <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					sda_oe_o <= 1'b0;
				end
				ST_ADDR, ST_RX:
				begin
					if (scl_rise)
					begin
						// Shift in MSB first
						shift_reg <= {shift_reg[6:0], sda_s_reg};
						cnt_reg   <= cnt_reg + 3'h1;
						full_reg  <= (cnt_reg == 3'h7);
					end
					else if (scl_fall && full_reg)
					begin
						full_reg <= 1'b0;
						if (state_reg == ST_ADDR)
						begin
							// Only the own address is matched, no general call
							if (shift_reg[7:1] == SLAVE_ADDR) // see R7, R8
							begin
								rw_reg    <= shift_reg[0];
								sda_oe_o  <= 1'b1; // see R11
								state_reg <= ST_ACK;
							end
							else
							begin
								state_reg <= ST_IGN; // see R23
							end
						end
						else
						begin
							if (ptr_phase_reg)
							begin
								// Pointer byte: upper three bits ignored
								ptr_reg       <= shift_reg[`IRS_PTR_W-1:0];
								ptr_phase_reg <= 1'b0;
							end
							else
							begin
								// Data byte stored, then pointer advances
								case (ptr_reg)
									`IRS_ADDR_RSVD0: ;
									`IRS_ADDR_RSVD1: ;
									`IRS_ADDR_KEY:
										wd_unlock_key_o <= shift_reg; // see R12
									`IRS_ADDR_WDCFG:
										if (wd_unlock_key_o == `IRS_KEY_UNLOCK) // see R21
											wd_config_o <= shift_reg;
									default:
										mem[ptr_reg] <= shift_reg; // see R12
								endcase
								ptr_reg <= ptr_inc; // see R13
							end
							sda_oe_o  <= 1'b1; // see R11
							state_reg <= ST_ACK; // see R5
						end
					end
				end
				ST_ACK:
				begin
					// After the 9th pulse release to receive, or drive the MSB to send
					if (scl_fall)
					begin
						cnt_reg  <= 3'h0;
						full_reg <= 1'b0;
						if (rw_reg)
						begin
							shift_reg <= {rd_data[6:0], 1'b0}; // see R17
							sda_oe_o  <= ~rd_data[7]; // see R3
							state_reg <= ST_TX;
						end
						else
						begin
							sda_oe_o  <= 1'b0; // see R6
							state_reg <= ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (scl_rise)
					begin
						cnt_reg  <= cnt_reg + 3'h1;
						full_reg <= (cnt_reg == 3'h7);
					end
					else if (scl_fall)
					begin
						if (full_reg)
						begin
							// Byte sent: free SDA for master acknowledge
							full_reg  <= 1'b0;
							sda_oe_o  <= 1'b0; // see R6
							ptr_reg   <= ptr_inc; // see R14
							state_reg <= ST_MACK;
						end
						else
						begin
							sda_oe_o  <= ~shift_reg[7]; // see R3
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
					begin
						mack_reg <= ~sda_s_reg;
					end
					else if (scl_fall)
					begin
						cnt_reg <= 3'h0;
						if (mack_reg)
						begin
							// Master acknowledged: next register out
							shift_reg <= {rd_data[6:0], 1'b0}; // see R19
							sda_oe_o  <= ~rd_data[7];
							state_reg <= ST_TX;
						end
						else
						begin
							// No acknowledge: stay off until start or stop
							sda_oe_o  <= 1'b0; // see R18
							state_reg <= ST_IGN;
						end
					end
				end
				ST_IGN:
				begin
					sda_oe_o <= 1'b0; // see R23
				end
				default:
				begin
					state_reg <= ST_IDLE;
					sda_oe_o  <= 1'b0;
				end
			endcase
		end
	end
end

endmodule
`default_nettype wire

// ---- irs_properties.sv ----
// Purpose: Pin checks for irs_i2c_slave
// Assumes: Pin events seen a few clocks late
// Notes:   Bound to the slave below
`timescale 1ns/100ps
`default_nettype none
module irs_props
(
	input wire logic       core_clk_i,
	input wire logic       reset_n_i,
	input wire logic       i2c_sel_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       busy_o,
	input wire logic [7:0] wd_unlock_key_o,
	input wire logic [7:0] wd_config_o,
	input wire logic       wd_unlocked_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Start and stop held at the pins
	sequence start_s;
		i2c_sel_i && scl_i && $fell(sda_i) ##1 (scl_i && !sda_i) [*3];
	endsequence
	sequence stop_s;
		scl_i && $rose(sda_i) ##1 (scl_i && sda_i) [*3];
	endsequence
	// Bus state, data pin and key gating
	busy_set_a: assert property (start_s |-> ##[0:4] busy_o)
		else $error("busy not set");
	busy_clear_a: assert property (stop_s |-> ##[0:4] !busy_o)
		else $error("busy not cleared");
	oe_scl_low_a: assert property ($changed(sda_oe_o) |-> $past(!scl_i, 3))
		else $error("data moved in clock high");
	idle_free_a: assert property (!busy_o [*2] |-> !sda_oe_o)
		else $error("data driven while idle");
	sel_free_a: assert property (!i2c_sel_i [*6] |-> !sda_oe_o)
		else $error("data driven while deselected");
	unlock_flag_a: assert property (wd_unlocked_o == ($past(wd_unlock_key_o) == 8'h5A))
		else $error("unlock flag wrong");
	cfg_locked_a: assert property ($changed(wd_config_o) |-> $past(wd_unlocked_o))
		else $error("config written while locked");
	key_in_xfer_a: assert property ($changed(wd_unlock_key_o) |-> busy_o)
		else $error("key changed outside transfer");
endmodule
bind irs_i2c_slave irs_props u_props (
	.core_clk_i      (core_clk_i),
	.reset_n_i       (reset_n_i),
	.i2c_sel_i       (i2c_sel_i),
	.scl_i           (scl_i),
	.sda_i           (sda_i),
	.sda_o           (sda_o),
	.sda_oe_o        (sda_oe_o),
	.busy_o          (busy_o),
	.wd_unlock_key_o (wd_unlock_key_o),
	.wd_config_o     (wd_config_o),
	.wd_unlocked_o   (wd_unlocked_o)
);
`default_nettype wire

// ---- irs_master_model.sv ----
// Purpose: Two-wire bus master model
// Assumes: 80 ns bit, data wire pulled up
// Notes:   Clock idles high between frames
`timescale 1ns/100ps
`default_nettype none
module irs_master
(
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_oe_o
);
	// Bus released at time zero
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Data moves mid low phase, sampled late in high phase
	task automatic bitx(input logic b, output logic r);
		w(2);
		sda_oe_o = !b;
		w(3);
		scl_o = 1'b1;
		w(2);
		r = sda_i;
		w(1);
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(a, k);
	endtask
	// Start when s is high, stop otherwise
	task automatic cond(input logic s);
		// Let the clock fall settle before the data wire moves
		w(2);
		sda_oe_o = !s;
		w(6);
		scl_o = 1'b1;
		w(4);
		sda_oe_o = s;
		w(4);
		scl_o = !s;
	endtask
endmodule
`default_nettype wire

// ---- irs_tb.sv ----
// Purpose: Self-checking bench for irs_i2c_slave
// Assumes: irs_master drives the bus
// Notes:   Data wire is pulled up
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       core_clk_i;
	logic       reset_n_i;
	logic       i2c_sel_i;
	logic       scl_i;
	logic       sda_o;
	logic       sda_oe_o;
	logic       busy_o;
	logic [7:0] wd_unlock_key_o;
	logic [7:0] wd_config_o;
	logic       wd_unlocked_o;
	logic       m_oe;
	logic       k;
	logic [7:0] q;
	int         fails = 0;
	int         n_checks = 0;
	wire        sda_i = !(m_oe || (sda_oe_o && !sda_o));
	// Slave and master share the data wire
	irs_i2c_slave uut (
		.core_clk_i      (core_clk_i),
		.reset_n_i       (reset_n_i),
		.i2c_sel_i       (i2c_sel_i),
		.scl_i           (scl_i),
		.sda_i           (sda_i),
		.sda_o           (sda_o),
		.sda_oe_o        (sda_oe_o),
		.busy_o          (busy_o),
		.wd_unlock_key_o (wd_unlock_key_o),
		.wd_config_o     (wd_config_o),
		.wd_unlocked_o   (wd_unlocked_o)
	);
	irs_master m (.clk_i(core_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_oe_o(m_oe));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// Start, bytes with acknowledge check, optional stop
	task automatic wr(input logic [7:0] b[$], input logic a, input logic fin);
		m.cond(1'b1);
		foreach (b[i])
		begin
			m.xfer(b[i], 1'b1, q, k);
			chk({7'h00, k}, {7'h00, a});
		end
		if (fin)
			m.cond(1'b0);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
		wr('{8'h00, p}, 1'b0, 1'b0);
		chk({7'h00, busy_o}, 8'h01);
		wr('{8'h01}, 1'b0, 1'b0);
		foreach (e[i])
		begin
			m.xfer(8'hFF, i == e.size() - 1, q, k);
			chk(q, e[i]);
		end
		m.cond(1'b0);
	endtask
	task automatic test_done();
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Clock and hang limit
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		repeat (15000) @(posedge core_clk_i);
		fails++;
		test_done();
	end
	// Main sequence
	initial
	begin
		reset_n_i = 1'b0;
		i2c_sel_i = 1'b1;
		repeat (12) @(posedge core_clk_i);
		#1 reset_n_i = 1'b1;
		m.w(4);
		chk({7'h00, sda_o}, 8'h00);
		chk({7'h00, busy_o}, 8'h00);
		chk(wd_unlock_key_o, 8'h00);
		chk(wd_config_o, 8'h09);
		wr('{8'h00, 8'h03, 8'hC3}, 1'b0, 1'b1);
		wr('{8'h00, 8'hE2, 8'h5A, 8'h3C}, 1'b0, 1'b1);
		chk(wd_unlock_key_o, 8'h5A);
		chk(wd_config_o, 8'h3C);
		wr('{8'h00, 8'h1F, 8'hD1, 8'h00, 8'h00, 8'h77, 8'h66}, 1'b0, 1'b1);
		chk(wd_unlock_key_o, 8'h77);
		chk({7'h00, busy_o}, 8'h00);
		rd(8'h02, '{8'h77, 8'h3C});
		rd(8'h1F, '{8'hD1, 8'h00, 8'h00});
		wr('{8'h24, 8'h02, 8'h55}, 1'b1, 1'b1);
		i2c_sel_i = 1'b0;
		wr('{8'h00, 8'h02, 8'h55}, 1'b1, 1'b1);
		i2c_sel_i = 1'b1;
		chk(wd_unlock_key_o, 8'h77);
		test_done();
	end
endmodule
`default_nettype wire
